// [include/fhc_pkg.sv]
// constants and types for the flash host controller
// assumes a 100 MHz clock and one attached byte-wide flash device
package fhc_pkg;
    // clock and timing figures, times in ns
    localparam int CLK_NS = 10;
    localparam int WE_PULSE_NS = 50;
    localparam int ACCESS_NS = 120;
    localparam int BUSY_ASSERT_NS = 100;   // busy_assert_delay
    localparam int WAKE_READ_NS = 400;     // wake_read_delay
    localparam int WAKE_WRITE_NS = 1000;   // wake_write_delay
    // least times round up to whole cycles
    localparam int WE_PULSE_CYC = (WE_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int BUSY_ASSERT_CYC = (BUSY_ASSERT_NS + CLK_NS - 1) / CLK_NS;
    localparam int WAKE_READ_CYC = (WAKE_READ_NS + CLK_NS - 1) / CLK_NS;
    localparam int WAKE_WRITE_CYC = (WAKE_WRITE_NS + CLK_NS - 1) / CLK_NS;
    // extra cycles for the input synchronisers and the registered pins
    localparam int SYNC_CYC = 3;

    // device command bytes
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_CONFIRM = 8'hD0;

    // device status bits and the value after power-down
    localparam int SR_VLOW = 3;
    localparam int SR_PFAIL = 4;
    localparam int SR_EFAIL = 5;
    localparam logic [7:0] SR_RESET = 8'h80;

    // software register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_RDATA = 8'h10;
    localparam int ST_ABORT_BIT = 5;
    localparam int ST_REFUSE_BIT = 6;

    typedef enum logic [2:0] {
        OP_NONE, OP_READ, OP_PROG, OP_ERASE, OP_STATUS, OP_CLEAR, OP_SLEEP, OP_WAKE
    } fhc_op_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_STEP, ST_SETUP, ST_PULSE, ST_HOLD, ST_BUSY_LO, ST_BUSY_HI
    } fhc_state_t;

    typedef enum logic [1:0] {ACT_WRITE, ACT_READ, ACT_WAIT, ACT_DONE} fhc_act_t;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic powerdown_reset_n;
    } fhc_pins_t;

    typedef struct packed {
        logic [7:0] last_sr;
        logic array_mode;
        logic refused;
        logic aborted;
        logic erase_fail;
        logic prog_fail;
        logic vlow_lock;
        logic asleep;
        logic busy;
    } fhc_stat_t;
endpackage

// [rtl/fhc_host.sv]
// host controller that drives one byte-wide flash over its pins
// assumes the flash pins are asynchronous; dq needs an external tri-state
//
// Summary of operation
// R1: device pulls busy low after command
// R2: device returns ready when sequencer done
// R3: device drives ready pin at all times
// R4: ready stays high suspended or asleep
// R5: voltage-low flag locks writes until clear
// R6: device flags program or erase failure
// R7: power-down during operation aborts; repeat it
// R8: power-down resets status upper bits 10000
// R9: command latch unaffected by supply, select
// R10: latch enters read array at wake
// R11: issue read array before array reads
// R12: write needs both write and select low
// R13: array changes only after two-step sequence
// R14: asleep device ignores all control inputs
// R15: wait wake delays before any access
// R16: deselected device keeps outputs off
// R17: read array command is FFH
// R18: asleep device floats its data bus
//
// Design decisions made here: the strobed register port and the placing of the registers.
module fhc_host (
    // clock, reset, enable
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    // software register port
    input wire logic [7:0] sw_addr_in,
    input wire logic [31:0] sw_wdata_in,
    input wire logic sw_wr_in,
    input wire logic sw_rd_in,
    output logic [31:0] sw_rdata_out,
    // flash pins
    output logic [19:0] flash_addr_out,
    output fhc_pkg::fhc_pins_t flash_ctl_out,
    output logic [7:0] flash_dq_out,
    output logic flash_dq_oe_out,
    input wire logic [7:0] flash_dq_in,
    input wire logic sequencer_idle_in
);
    localparam logic [7:0] WE_LAST = 8'(fhc_pkg::WE_PULSE_CYC - 1);
    localparam logic [7:0] RD_LAST = 8'(fhc_pkg::ACCESS_CYC + fhc_pkg::SYNC_CYC - 1);
    localparam logic [7:0] BUSY_LAST = 8'(fhc_pkg::BUSY_ASSERT_CYC + fhc_pkg::SYNC_CYC);
    localparam logic [11:0] WAKE_RD = 12'(fhc_pkg::WAKE_READ_CYC);
    localparam logic [11:0] WAKE_WR = 12'(fhc_pkg::WAKE_WRITE_CYC);

    fhc_pkg::fhc_state_t state;
    fhc_pkg::fhc_op_t op;
    fhc_pkg::fhc_op_t req_op;
    fhc_pkg::fhc_act_t act_kind;
    fhc_pkg::fhc_stat_t stat;
    logic [7:0] act_byte;
    logic [3:0] step;
    logic [7:0] cnt;
    logic [19:0] addr_reg;
    logic [7:0] wdata_reg;
    logic [7:0] rdata_reg;
    logic [7:0] last_sr;
    logic [7:0] bus_byte;
    logic [11:0] wake_cnt;
    logic is_read;
    logic array_mode;
    logic refused;
    logic aborted;
    logic pd_n;
    logic idle_meta;
    logic idle_sync;
    logic [7:0] dq_meta;
    logic [7:0] dq_sync;
    logic ctrl_wr;
    logic busy;
    logic start_ok;
    logic sleep_ev;
    logic wake_ev;
    logic refuse_ev;
    logic abort_ev;
    logic pulse_end;

    // request decode from the software port
    assign ctrl_wr = sw_wr_in && (sw_addr_in == fhc_pkg::REG_CTRL);
    assign req_op = fhc_pkg::fhc_op_t'(sw_wdata_in[2:0]);
    assign busy = (state != fhc_pkg::ST_IDLE);
    assign sleep_ev = ctrl_wr && (req_op == fhc_pkg::OP_SLEEP);
    assign wake_ev = ctrl_wr && (req_op == fhc_pkg::OP_WAKE) && !pd_n;
    assign abort_ev = sleep_ev && busy;  // R7
    // program and erase stay locked while the voltage-low flag is seen
    assign start_ok = ctrl_wr && pd_n && !busy
        && (req_op inside {fhc_pkg::OP_READ, fhc_pkg::OP_STATUS, fhc_pkg::OP_CLEAR}
        || ((req_op == fhc_pkg::OP_PROG || req_op == fhc_pkg::OP_ERASE)
        && !last_sr[fhc_pkg::SR_VLOW]));  // R5
    assign refuse_ev = ctrl_wr && !start_ok && !sleep_ev && !wake_ev;
    assign pulse_end = (state == fhc_pkg::ST_PULSE) && (cnt == (is_read ? RD_LAST : WE_LAST));

    // two-flop synchronisers for the asynchronous pins
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            idle_meta <= 1'b1;
            idle_sync <= 1'b1;
            dq_meta <= 8'h00;
            dq_sync <= 8'h00;
        end else if (clk_en_in) begin
            idle_meta <= sequencer_idle_in;
            idle_sync <= idle_meta;
            dq_meta <= flash_dq_in;
            dq_sync <= dq_meta;
        end
    end

    // step table: each operation as a list of bus actions
    always_comb begin
        act_kind = fhc_pkg::ACT_DONE;
        act_byte = fhc_pkg::CMD_READ_ARRAY;
        case (op)
            fhc_pkg::OP_READ: begin
                // the array read is preceded by read array unless already there
                if (step == 4'h0) begin
                    act_kind = fhc_pkg::ACT_WRITE;  // R11
                end else if (step == 4'h1) begin
                    act_kind = fhc_pkg::ACT_READ;
                end
            end
            fhc_pkg::OP_PROG, fhc_pkg::OP_ERASE: begin
                case (step)
                    4'h0: begin
                        act_kind = fhc_pkg::ACT_WRITE;
                        act_byte = (op == fhc_pkg::OP_PROG) ? fhc_pkg::CMD_PROG_SETUP
                            : fhc_pkg::CMD_ERASE_SETUP;
                    end
                    4'h1: begin
                        act_kind = fhc_pkg::ACT_WRITE;
                        act_byte = (op == fhc_pkg::OP_PROG) ? wdata_reg : fhc_pkg::CMD_CONFIRM;
                    end
                    4'h2: act_kind = fhc_pkg::ACT_WAIT;
                    4'h3: begin
                        act_kind = fhc_pkg::ACT_WRITE;
                        act_byte = fhc_pkg::CMD_READ_STATUS;
                    end
                    4'h4: act_kind = fhc_pkg::ACT_READ;
                    4'h5: act_kind = fhc_pkg::ACT_WRITE;  // R17
                    default: act_kind = fhc_pkg::ACT_DONE;
                endcase
            end
            fhc_pkg::OP_STATUS: begin
                if (step == 4'h0) begin
                    act_kind = fhc_pkg::ACT_WRITE;
                    act_byte = fhc_pkg::CMD_READ_STATUS;
                end else if (step == 4'h1) begin
                    act_kind = fhc_pkg::ACT_READ;
                end else if (step == 4'h2) begin
                    act_kind = fhc_pkg::ACT_WRITE;
                end
            end
            fhc_pkg::OP_CLEAR: begin
                if (step == 4'h0) begin
                    act_kind = fhc_pkg::ACT_WRITE;
                    act_byte = fhc_pkg::CMD_CLEAR_STATUS;  // R5
                end else if (step == 4'h1) begin
                    act_kind = fhc_pkg::ACT_WRITE;
                end
            end
            default: act_kind = fhc_pkg::ACT_DONE;
        endcase
    end

    // main sequencer; a sleep request cuts any operation short
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state <= fhc_pkg::ST_IDLE;
            step <= 4'h0;
            cnt <= 8'h00;
            is_read <= 1'b0;
            bus_byte <= 8'h00;
        end else if (clk_en_in) begin
            if (sleep_ev) begin
                state <= fhc_pkg::ST_IDLE;  // R7
            end else begin
                case (state)
                    fhc_pkg::ST_IDLE: begin
                        if (start_ok) begin
                            state <= fhc_pkg::ST_STEP;
                            step <= (req_op == fhc_pkg::OP_READ && array_mode) ? 4'h1 : 4'h0;
                        end
                    end
                    fhc_pkg::ST_STEP: begin
                        case (act_kind)
                            fhc_pkg::ACT_WRITE: begin
                                // no write strobe before the wake write delay
                                if (wake_cnt >= WAKE_WR) begin  // R15
                                    state <= fhc_pkg::ST_SETUP;
                                    is_read <= 1'b0;
                                    bus_byte <= act_byte;
                                end
                            end
                            fhc_pkg::ACT_READ: begin
                                if (wake_cnt >= WAKE_RD) begin  // R15
                                    state <= fhc_pkg::ST_SETUP;
                                    is_read <= 1'b1;
                                end
                            end
                            fhc_pkg::ACT_WAIT: begin
                                state <= fhc_pkg::ST_BUSY_LO;
                                cnt <= 8'h00;
                            end
                            default: state <= fhc_pkg::ST_IDLE;
                        endcase
                    end
                    fhc_pkg::ST_SETUP: begin
                        state <= fhc_pkg::ST_PULSE;
                        cnt <= 8'h00;
                    end
                    fhc_pkg::ST_PULSE: begin
                        cnt <= cnt + 8'h01;
                        if (pulse_end) begin
                            state <= fhc_pkg::ST_HOLD;
                        end
                    end
                    fhc_pkg::ST_HOLD: begin
                        state <= fhc_pkg::ST_STEP;
                        step <= step + 4'h1;
                    end
                    fhc_pkg::ST_BUSY_LO: begin
                        // a very short operation may finish before busy is seen
                        cnt <= cnt + 8'h01;
                        if (!idle_sync || cnt == BUSY_LAST) begin
                            state <= fhc_pkg::ST_BUSY_HI;
                        end
                    end
                    fhc_pkg::ST_BUSY_HI: begin
                        // no timeout: a hung device is left by a sleep request
                        if (idle_sync) begin
                            state <= fhc_pkg::ST_STEP;
                            step <= step + 4'h1;
                        end
                    end
                    default: state <= fhc_pkg::ST_IDLE;
                endcase
            end
        end
    end

    // operation register, power-down level and wake counter
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            op <= fhc_pkg::OP_NONE;
            pd_n <= 1'b1;
            wake_cnt <= 12'h000;
        end else if (clk_en_in) begin
            if (start_ok || sleep_ev || wake_ev) begin
                op <= req_op;
            end
            if (sleep_ev) begin
                pd_n <= 1'b0;
            end else if (wake_ev) begin
                pd_n <= 1'b1;
            end
            // counts from the pin so the delay runs from the real edge
            if (!flash_ctl_out.powerdown_reset_n) begin
                wake_cnt <= 12'h000;  // R15
            end else if (wake_cnt != 12'hFFF) begin
                wake_cnt <= wake_cnt + 12'h001;
            end
        end
    end

    // captured data, mirrored device status and read array tracking
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rdata_reg <= 8'h00;
            last_sr <= fhc_pkg::SR_RESET;
            array_mode <= 1'b1;
        end else if (clk_en_in) begin
            if (sleep_ev) begin
                last_sr <= fhc_pkg::SR_RESET;  // device status resets on power-down
                array_mode <= 1'b1;            // device wakes in read array
            end else if (pulse_end && is_read) begin
                if (op == fhc_pkg::OP_READ) begin
                    rdata_reg <= dq_sync;
                end else begin
                    last_sr <= dq_sync;
                end
            end else if (state == fhc_pkg::ST_HOLD && !is_read) begin
                array_mode <= (bus_byte == fhc_pkg::CMD_READ_ARRAY);
                if (bus_byte == fhc_pkg::CMD_CLEAR_STATUS && op == fhc_pkg::OP_CLEAR) begin
                    last_sr[fhc_pkg::SR_EFAIL:fhc_pkg::SR_VLOW] <= 3'h0;  // R5
                end
            end
        end
    end

    // pins are registered from the state, so strobes never glitch
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            flash_ctl_out <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, powerdown_reset_n: 1'b1};
            flash_addr_out <= 20'h0_0000;
            flash_dq_out <= 8'h00;
            flash_dq_oe_out <= 1'b0;
        end else if (clk_en_in) begin
            flash_ctl_out.ce_n <= !(state inside
                {fhc_pkg::ST_SETUP, fhc_pkg::ST_PULSE, fhc_pkg::ST_HOLD});
            flash_ctl_out.we_n <= !(state == fhc_pkg::ST_PULSE && !is_read);
            flash_ctl_out.oe_n <= !(state == fhc_pkg::ST_PULSE && is_read);
            flash_ctl_out.powerdown_reset_n <= pd_n;  // R7
            flash_addr_out <= addr_reg;
            flash_dq_out <= bus_byte;
            // dq is driven only across a write, never while oe is low
            flash_dq_oe_out <= !is_read && (state inside
                {fhc_pkg::ST_SETUP, fhc_pkg::ST_PULSE, fhc_pkg::ST_HOLD});
        end
    end

    // software writes; sticky flags, a new event wins over its clear
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            addr_reg <= 20'h0_0000;
            wdata_reg <= 8'h00;
            refused <= 1'b0;
            aborted <= 1'b0;
        end else if (clk_en_in) begin
            if (sw_wr_in && sw_addr_in == fhc_pkg::REG_ADDR && !busy) begin
                addr_reg <= sw_wdata_in[19:0];
            end
            if (sw_wr_in && sw_addr_in == fhc_pkg::REG_WDATA && !busy) begin
                wdata_reg <= sw_wdata_in[7:0];
            end
            if (refuse_ev) begin
                refused <= 1'b1;  // R5
            end else if (sw_wr_in && sw_addr_in == fhc_pkg::REG_STATUS
                && sw_wdata_in[fhc_pkg::ST_REFUSE_BIT]) begin
                refused <= 1'b0;
            end
            if (abort_ev) begin
                aborted <= 1'b1;  // R7
            end else if (sw_wr_in && sw_addr_in == fhc_pkg::REG_STATUS
                && sw_wdata_in[fhc_pkg::ST_ABORT_BIT]) begin
                aborted <= 1'b0;
            end
        end
    end

    // status word seen by software
    assign stat = '{last_sr: last_sr, array_mode: array_mode, refused: refused,
        aborted: aborted, erase_fail: last_sr[fhc_pkg::SR_EFAIL],
        prog_fail: last_sr[fhc_pkg::SR_PFAIL], vlow_lock: last_sr[fhc_pkg::SR_VLOW],
        asleep: !pd_n, busy: busy};

    // read data stand only in the cycle after the strobe
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sw_rdata_out <= 32'h0000_0000;
        end else if (clk_en_in) begin
            sw_rdata_out <= 32'h0000_0000;
            if (sw_rd_in) begin
                case (sw_addr_in)
                    fhc_pkg::REG_CTRL: sw_rdata_out <= {29'h0, op};
                    fhc_pkg::REG_ADDR: sw_rdata_out <= {12'h000, addr_reg};
                    fhc_pkg::REG_WDATA: sw_rdata_out <= {24'h00_0000, wdata_reg};
                    fhc_pkg::REG_STATUS: sw_rdata_out <= {16'h0000, stat};
                    fhc_pkg::REG_RDATA: sw_rdata_out <= {24'h00_0000, rdata_reg};
                    default: sw_rdata_out <= 32'h0000_0000;
                endcase
            end
        end
    end

    // checks on the controller's own behaviour
    default clocking fhc_cb @(posedge mclk_in);
    endclocking
    default disable iff (sys_rst_in);

    a_lock_blocks_start: // R5
        assert property (clk_en_in && ctrl_wr && last_sr[fhc_pkg::SR_VLOW]
            && (req_op == fhc_pkg::OP_PROG || req_op == fhc_pkg::OP_ERASE)
            |=> refused && !(state == fhc_pkg::ST_STEP && step == 4'h0))
        else $error("program or erase started under voltage-low lock");
    a_abort_drops_op: // R7
        assert property (clk_en_in && abort_ev
            |=> state == fhc_pkg::ST_IDLE && aborted && !pd_n)
        else $error("sleep during an operation did not abort it");
    a_abort_pin_low: // R7
        assert property (clk_en_in && sleep_ev ##1 clk_en_in
            |=> !flash_ctl_out.powerdown_reset_n)
        else $error("power-down pin not lowered after sleep");
    a_read_in_array: // R11
        assert property ($fell(flash_ctl_out.oe_n) && op == fhc_pkg::OP_READ |-> array_mode)
        else $error("array read without read array mode");
    a_array_after_write: // R17
        assert property (state == fhc_pkg::ST_STEP && act_kind == fhc_pkg::ACT_DONE
            && (op == fhc_pkg::OP_PROG || op == fhc_pkg::OP_ERASE) |-> array_mode)
        else $error("program or erase ended without read array");
    a_wake_write_wait: // R15
        assert property ($fell(flash_ctl_out.we_n) |-> wake_cnt >= WAKE_WR)
        else $error("write strobe inside wake write delay");
    a_wake_read_wait: // R15
        assert property ($fell(flash_ctl_out.oe_n) |-> wake_cnt >= WAKE_RD)
        else $error("read strobe inside wake read delay");
    a_quiet_asleep: // R14
        assert property (!flash_ctl_out.powerdown_reset_n
            |-> flash_ctl_out.ce_n && flash_ctl_out.we_n && !flash_dq_oe_out)
        else $error("pins active while device asleep");

    c_prog_done: cover property (op == fhc_pkg::OP_PROG && state == fhc_pkg::ST_BUSY_HI
        ##1 state == fhc_pkg::ST_STEP);
    c_erase_done: cover property (op == fhc_pkg::OP_ERASE && state == fhc_pkg::ST_BUSY_HI
        ##1 state == fhc_pkg::ST_STEP);
    c_wake_read: cover property (wake_ev ##[1:300] $fell(flash_ctl_out.oe_n));
endmodule

// [testbench/fhc_flash_model.sv]
// behavioural byte-wide flash that answers the host controller pins
// assumes pins come from fhc_host; array folded to 16 bytes by addr bits 3:0
module fhc_flash_model (
    // pins from the host
    input wire logic [19:0] addr_in,
    input wire fhc_pkg::fhc_pins_t pins_in,
    input wire logic [7:0] dq_in,
    // fault injection from the bench
    input wire logic vlow_in,
    input wire logic fail_in,
    // pins to the host
    output logic [7:0] dq_out,
    output logic ready_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [16];
    logic [7:0] sr = 8'h80;
    logic [7:0] pend = 8'h00;
    logic [7:0] d;
    logic [7:0] junk = 8'h5A;
    logic stat_mode = 1'b0;
    logic [3:0] a;
    // erased array, ready pin driven from the start
    initial begin
        ready_out = 1'b1;
        foreach (mem[i]) mem[i] = 8'hFF;
    end
    // released bus shows a changing pattern so stale data cannot pass
    always #10 junk = ~junk + 8'h01;
    assign dq_out = (!pins_in.ce_n && !pins_in.oe_n && pins_in.powerdown_reset_n) ?
        (stat_mode ? sr : mem[addr_in[3:0]]) : junk;
    // power-down clears status, wake returns to array reads
    always @(negedge pins_in.powerdown_reset_n) sr = 8'h80;
    always @(posedge pins_in.powerdown_reset_n) begin
        stat_mode = 1'b0;
        pend = 8'h00;
    end
    // commands latched at the end of a write strobe; blocks while busy
    always @(posedge pins_in.we_n) begin
        d = dq_in;
        a = addr_in[3:0];
        if (!pins_in.ce_n && pins_in.powerdown_reset_n && ready_out) begin
            if (pend == fhc_pkg::CMD_PROG_SETUP ||
                (pend == fhc_pkg::CMD_ERASE_SETUP && d == fhc_pkg::CMD_CONFIRM)) begin
                stat_mode = 1'b1;
                #50 ready_out = 1'b0;
                sr[7] = 1'b0;
                #400;
                if (vlow_in || sr[3]) sr[3] = 1'b1;
                else if (fail_in) sr[pend == fhc_pkg::CMD_PROG_SETUP ? 4 : 5] = 1'b1;
                else if (pend == fhc_pkg::CMD_PROG_SETUP) mem[a] = mem[a] & d;
                else foreach (mem[i]) mem[i] = 8'hFF;
                sr[7] = 1'b1;
                ready_out = 1'b1;
                pend = 8'h00;
            end else begin
                if (d == fhc_pkg::CMD_READ_ARRAY) stat_mode = 1'b0;
                if (d == fhc_pkg::CMD_READ_STATUS) stat_mode = 1'b1;
                if (d == fhc_pkg::CMD_CLEAR_STATUS) sr[5:3] = 3'h0;
                pend = (d == fhc_pkg::CMD_PROG_SETUP || d == fhc_pkg::CMD_ERASE_SETUP) ? d : 8'h00;
            end
        end
    end
endmodule

// [testbench/test_fhc_host.sv]
// self-checking bench for the flash host controller
// assumes fhc_flash_model on the flash pins and one 100 MHz clock
module test_fhc_host;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [7:0] sw_addr_in = 8'h00;
    logic [31:0] sw_wdata_in = 32'h0000_0000;
    logic sw_wr_in = 1'b0;
    logic sw_rd_in = 1'b0;
    logic vlow = 1'b0;
    logic fail = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] d8;
    logic [31:0] sw_rdata_out;
    logic [19:0] flash_addr_out;
    fhc_pkg::fhc_pins_t flash_ctl_out;
    logic [7:0] flash_dq_out;
    logic flash_dq_oe_out;
    logic [7:0] mdl_dq;
    logic [7:0] dq_bus;
    logic sequencer_idle_in;
    logic [7:0] exp_mem [16];
    logic [31:0] st;
    logic [19:0] fa;
    int n_mismatch = 0;
    int n_checks = 0;
    // shared data wire: host wins while its enable is high
    assign dq_bus = flash_dq_oe_out ? flash_dq_out : mdl_dq;
    fhc_host dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en),
        .sw_addr_in(sw_addr_in), .sw_wdata_in(sw_wdata_in), .sw_wr_in(sw_wr_in),
        .sw_rd_in(sw_rd_in), .sw_rdata_out(sw_rdata_out), .flash_addr_out(flash_addr_out),
        .flash_ctl_out(flash_ctl_out), .flash_dq_out(flash_dq_out),
        .flash_dq_oe_out(flash_dq_oe_out), .flash_dq_in(dq_bus),
        .sequencer_idle_in(sequencer_idle_in));
    fhc_flash_model flash (.addr_in(flash_addr_out), .pins_in(flash_ctl_out), .dq_in(dq_bus),
        .vlow_in(vlow), .fail_in(fail), .dq_out(mdl_dq), .ready_out(sequencer_idle_in));
    // free-running clock
    always #5 mclk_in = ~mclk_in;
    // one-cycle register strobes, a quiet edge after each
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        sw_addr_in <= a;
        sw_wdata_in <= d;
        sw_wr_in <= 1'b1;
        @(posedge mclk_in);
        sw_wr_in <= 1'b0;
        @(posedge mclk_in);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        sw_addr_in <= a;
        sw_rd_in <= 1'b1;
        @(posedge mclk_in);
        sw_rd_in <= 1'b0;
        #1 d = sw_rdata_out;
        @(posedge mclk_in);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // a program can only clear bits of the stored byte
    function automatic logic [7:0] prog_result(input logic [7:0] old, input logic [7:0] d);
        return old & d;
    endfunction
    // start an operation and poll status until busy drops, bounded
    task automatic op(input fhc_pkg::fhc_op_t o);
        int i;
        wr(fhc_pkg::REG_CTRL, {29'h0000_0000, o});
        for (i = 0; i < 3000 && (i == 0 || st[0] !== 1'b0); i++) rd(fhc_pkg::REG_STATUS, st);
        if (i == 3000) n_mismatch++;
    endtask
    task automatic prog(input logic [19:0] a, input logic [7:0] d);
        wr(fhc_pkg::REG_ADDR, {12'h000, a});
        wr(fhc_pkg::REG_WDATA, {24'h00_0000, d});
        op(fhc_pkg::OP_PROG);
    endtask
    task automatic rd_arr(input logic [19:0] a);
        wr(fhc_pkg::REG_ADDR, {12'h000, a});
        op(fhc_pkg::OP_READ);
        rd(fhc_pkg::REG_RDATA, st);
        chk(st, {24'h00_0000, exp_mem[a[3:0]]});
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // watchdog: the whole sequence needs well under this span
    initial begin
        #500_000;
        n_mismatch++;
        results();
    end
    // main sequence
    initial begin
        void'($urandom(97));
        foreach (exp_mem[i]) exp_mem[i] = 8'hFF;
        repeat (6) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        @(posedge mclk_in);
        rd(8'h20, st);
        chk(st, 32'h0000_0000);
        // address extremes first, then random bytes; bits only ever clear
        for (int k = 0; k < 6; k++) begin
            fa = (k == 0) ? 20'h0_0000 : (k == 1) ? 20'hF_FFFF : 20'($urandom);
            d8 = 8'($urandom);
            exp_mem[fa[3:0]] = prog_result(exp_mem[fa[3:0]], d8);
            prog(fa, d8);
            chk(st & 32'h0000_FF78, 32'h0000_8000);
            rd_arr(fa);
        end
        // failures flagged and left uncleared
        fail <= 1'b1;
        prog(fa, 8'h00);
        chk(st & 32'h0000_FF18, 32'h0000_9008);
        op(fhc_pkg::OP_ERASE);
        chk(st & 32'h0000_FF18, 32'h0000_B018);
        fail <= 1'b0;
        // sleep cuts a fresh program short, clears the status byte, ready stays high
        wr(fhc_pkg::REG_CTRL, {29'h0000_0000, fhc_pkg::OP_PROG});
        op(fhc_pkg::OP_SLEEP);
        chk(st & 32'h0000_FF22, 32'h0000_8022);
        chk({31'h0000_0000, sequencer_idle_in}, 32'h0000_0001);
        op(fhc_pkg::OP_WAKE);
        op(fhc_pkg::OP_STATUS);
        chk(st & 32'h0000_FF1A, 32'h0000_8000);
        rd_arr(fa);
        // low programming voltage locks until a clear
        vlow <= 1'b1;
        prog(fa, 8'h00);
        chk(st & 32'h0000_FF04, 32'h0000_8804);
        vlow <= 1'b0;
        prog(fa, 8'h00);
        chk(st & 32'h0000_0040, 32'h0000_0040);
        wr(fhc_pkg::REG_STATUS, 32'h0000_0040);
        op(fhc_pkg::OP_CLEAR);
        exp_mem[fa[3:0]] = 8'h00;
        prog(fa, 8'h00);
        chk(st & 32'h0000_FF44, 32'h0000_8000);
        rd_arr(fa);
        // erase returns every byte to all ones
        op(fhc_pkg::OP_ERASE);
        foreach (exp_mem[i]) exp_mem[i] = 8'hFF;
        rd_arr(fa);
        // frozen enable: a register write is lost and the address kept
        clk_en <= 1'b0;
        wr(fhc_pkg::REG_ADDR, $urandom);
        clk_en <= 1'b1;
        rd(fhc_pkg::REG_ADDR, st);
        chk(st, {12'h000, fa});
        results();
    end
endmodule
